// >>> hdl/sucr_defines.vh
/*
 * Constants for the user configuration register bank: register
 * indexes, field positions, write masks, reset values, serial bus
 * address and start-up timing.
 * Assumes inclusion by the design file and the bench that need it.
 */
`ifndef SUCR_DEFINES_VH
`define SUCR_DEFINES_VH

// Register indexes, sent as the command byte after the address
`define SUCR_IDX_RES_HEAT 8'h00
`define SUCR_IDX_AUX 8'h01
`define SUCR_IDX_HEAT_LVL 8'h02

// Reset values
`define SUCR_RST_RES_HEAT 8'h3A
`define SUCR_RST_AUX 8'h08
`define SUCR_RST_HEAT_LVL 8'h00

// Writable bits per register; the rest are reserved or read-only
`define SUCR_WMASK_RES_HEAT 8'h85
`define SUCR_WMASK_AUX 8'h77
`define SUCR_WMASK_HEAT_LVL 8'h0F

// Field positions, first register
`define SUCR_BIT_RES_MSB 7
`define SUCR_BIT_SUPPLY_LOW 6
`define SUCR_BIT_HEATER_SW 2
`define SUCR_BIT_RES_LSB 0
// Field positions, second register
`define SUCR_BIT_NO_HOLD 6
`define SUCR_BIT_THERM_LIN 5
`define SUCR_BIT_CONV_SPEED 4
`define SUCR_BIT_IN_BUF 2
`define SUCR_BIT_REF_SEL 1
`define SUCR_BIT_DRIVE_PIN 0
// Field positions, third register
`define SUCR_HEAT_LVL_MSB 3

// Upper six bits of the 7-bit bus address, value arbitrary
`define SUCR_BUS_ADDR_HI 6'h2A

// Settling time of the strap pin before it is captured
`define SUCR_STRAP_SETTLE_NS 100
`define SUCR_CLK_PERIOD_NS 10
`define SUCR_STRAP_CYCLES \
    ((`SUCR_STRAP_SETTLE_NS + `SUCR_CLK_PERIOD_NS - 1) / `SUCR_CLK_PERIOD_NS)

`endif

// >>> hdl/sucr_user_config.v
/*
 * User configuration and status registers of the humidity and
 * two-zone temperature sensor, with the small two-wire serial slave
 * that reaches them, the strap capture of the dual-function pin and
 * the control outputs into the analog side.
 * Assumes scl, sda, strap pin and supply-low level are asynchronous
 * to clk_in; clk_in is much faster (100 MHz) than the serial clock.
 */
`timescale 1ns/1ps
`include "sucr_defines.vh"

// How it works
// - Two-bit resolution field in bits 7 and 0
// - First register resets to 0011_1010
// - Read-only supply-low flag, bit 6
// - Bit 2 switches the heater on or off
// - Second register resets to 0000_100, pin level
// - Bit 6 selects no-hold auxiliary measurements
// - Bit 5 enables thermistor correction
// - Bit 4 selects fast auxiliary conversion
// - Bit 2 buffers the auxiliary differential inputs
// - Bit 1 selects analog supply reference
// - Bit 0 drives the dual-function pin level
// - Pin bit default equals pin power-up level
// - Third register resets to all zeros
// - Low four bits set heater power level
// - Reserved bits fixed, ignore writes, unlisted ignored
module sucr_user_config (
    input wire clk_in,
    input wire rst_n_in,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output reg sda_oe_out,
    input wire address_select_drive_pin_in,
    output wire address_select_drive_pin_out,
    output reg address_select_drive_pin_oe_out,
    input wire supply_low_in,
    output wire [1:0] resolution_select_out,
    output wire heater_switch_out,
    output wire [3:0] heater_drive_level_out,
    output wire aux_no_hold_out,
    output wire thermistor_linearize_en_out,
    output wire aux_conversion_speed_out,
    output wire aux_input_buffer_en_out,
    output wire converter_reference_select_out
);

    // One-hot serial slave states
    localparam [8:0] ST_IDLE = 9'h001;
    localparam [8:0] ST_ADDR = 9'h002;
    localparam [8:0] ST_AACK = 9'h004;
    localparam [8:0] ST_CMD = 9'h008;
    localparam [8:0] ST_CACK = 9'h010;
    localparam [8:0] ST_WDAT = 9'h020;
    localparam [8:0] ST_WACK = 9'h040;
    localparam [8:0] ST_RDAT = 9'h080;
    localparam [8:0] ST_RACK = 9'h100;
    // Settling count at full width, then cut to the counter's width
    localparam [31:0] STRAP_CYCLES_W = `SUCR_STRAP_CYCLES;
    localparam [7:0] STRAP_CYCLES = STRAP_CYCLES_W[7:0];

    // Synchroniser stages: index 0 first, 1 second, 2 edge history
    reg [2:0] scl_sync; // Serial clock
    reg [2:0] sda_sync; // Serial data
    reg [1:0] pin_sync; // Strap level of the dual-function pin
    reg [1:0] low_sync; // Supply-low level
    // Register contents
    reg [7:0] res_heat; // First register, writable bits
    reg [7:0] aux_ctrl; // Second register, writable bits
    reg [7:0] heat_lvl; // Third register, writable bits
    // Serial slave state
    reg [8:0] state; // Current state
    reg [3:0] bit_cnt; // Bits taken in the current byte
    reg [7:0] shift_in; // Incoming byte
    reg [7:0] shift_out; // Outgoing byte
    reg [7:0] reg_ptr; // Register selected by the command byte
    reg read_dir; // Address byte asked for a read
    reg host_nack; // Host refused the last read byte
    reg addr_lsb; // Bus address bit taken from the strap
    // Strap capture
    reg [7:0] strap_cnt; // Settling counter after reset release
    reg strap_done; // Strap captured, pin now driven

    // Bus events seen on the synchronised lines
    wire scl_rise = scl_sync[1] & ~scl_sync[2];
    wire scl_fall = ~scl_sync[1] & scl_sync[2];
    wire bus_start = scl_sync[1] & scl_sync[2] & ~sda_sync[1] & sda_sync[2];
    wire bus_stop = scl_sync[1] & scl_sync[2] & sda_sync[1] & ~sda_sync[2];
    wire addr_hit = (shift_in[7:1] == {`SUCR_BUS_ADDR_HI, addr_lsb});
    wire ptr_valid = (reg_ptr == `SUCR_IDX_RES_HEAT) |
                     (reg_ptr == `SUCR_IDX_AUX) |
                     (reg_ptr == `SUCR_IDX_HEAT_LVL);
    wire cmd_valid = (shift_in == `SUCR_IDX_RES_HEAT) |
                     (shift_in == `SUCR_IDX_AUX) |
                     (shift_in == `SUCR_IDX_HEAT_LVL);

    // Read views; reserved bits hold their fixed values
    wire [7:0] view_res_heat = (res_heat & `SUCR_WMASK_RES_HEAT) |
                               (`SUCR_RST_RES_HEAT &
                                ~`SUCR_WMASK_RES_HEAT &
                                ~(8'h01 << `SUCR_BIT_SUPPLY_LOW)) |
                               ({7'h00, low_sync[1]}
                                << `SUCR_BIT_SUPPLY_LOW);
    wire [7:0] view_aux = (aux_ctrl & `SUCR_WMASK_AUX) |
                          (`SUCR_RST_AUX & ~`SUCR_WMASK_AUX);
    wire [7:0] view_heat_lvl = heat_lvl & `SUCR_WMASK_HEAT_LVL;
    reg [7:0] read_byte; // Byte selected for a read

    // Read multiplexer; unlisted locations read as all ones
    always @* begin
        case (reg_ptr)
            `SUCR_IDX_RES_HEAT: read_byte = view_res_heat;
            `SUCR_IDX_AUX: read_byte = view_aux;
            `SUCR_IDX_HEAT_LVL: read_byte = view_heat_lvl;
            default: read_byte = 8'hFF;
        endcase
    end

    // Synchronisers for every asynchronous input
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            pin_sync <= 2'h0;
            low_sync <= 2'h0;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_in};
            sda_sync <= {sda_sync[1:0], sda_in};
            pin_sync <= {pin_sync[0], address_select_drive_pin_in};
            low_sync <= {low_sync[0], supply_low_in};
        end
    end

    // Strap capture: wait, then take the pin level once
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strap_cnt <= 8'h00;
            strap_done <= 1'b0;
            addr_lsb <= 1'b0;
            address_select_drive_pin_oe_out <= 1'b0;
        end else if (!strap_done) begin
            if (strap_cnt == STRAP_CYCLES) begin
                strap_done <= 1'b1;
                addr_lsb <= pin_sync[1];
                address_select_drive_pin_oe_out <= 1'b1;
            end else begin
                strap_cnt <= strap_cnt + 8'h01;
            end
        end
    end

    // Serial slave and register writes
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift_in <= 8'h00;
            shift_out <= 8'hFF;
            reg_ptr <= 8'h00;
            read_dir <= 1'b0;
            host_nack <= 1'b0;
            sda_oe_out <= 1'b0;
            res_heat <= `SUCR_RST_RES_HEAT;
            aux_ctrl <= `SUCR_RST_AUX & ~`SUCR_WMASK_AUX;
            heat_lvl <= `SUCR_RST_HEAT_LVL;
        end else begin
            // Strap level enters the pin bit at capture
            if (!strap_done && strap_cnt == STRAP_CYCLES) begin
                aux_ctrl[`SUCR_BIT_DRIVE_PIN] <= pin_sync[1];
            end
            if (bus_start) begin
                // Start or repeated start restarts the address byte
                state <= ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe_out <= 1'b0;
            end else if (bus_stop) begin
                // Stop ends any transfer
                state <= ST_IDLE;
                sda_oe_out <= 1'b0;
            end else if (scl_rise) begin
                // Sample on the rising serial clock
                if (state == ST_RACK) begin
                    host_nack <= sda_sync[1];
                end else if (state != ST_AACK && state != ST_CACK &&
                             state != ST_WACK) begin
                    // Own ack clocks must not shift the byte to commit
                    shift_in <= {shift_in[6:0], sda_sync[1]};
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end else if (scl_fall) begin
                // Act on the falling serial clock
                case (state)
                    ST_ADDR: begin
                        if (bit_cnt == 4'h8) begin
                            if (addr_hit && strap_done) begin
                                state <= ST_AACK;
                                read_dir <= shift_in[0];
                                sda_oe_out <= 1'b1;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        bit_cnt <= 4'h0;
                        if (read_dir) begin
                            state <= ST_RDAT;
                            shift_out <= {read_byte[6:0], 1'b1};
                            sda_oe_out <= ~read_byte[7];
                        end else begin
                            state <= ST_CMD;
                            sda_oe_out <= 1'b0;
                        end
                    end
                    ST_CMD: begin
                        if (bit_cnt == 4'h8) begin
                            // Unlisted locations are not acknowledged
                            if (cmd_valid) begin
                                state <= ST_CACK;
                                reg_ptr <= shift_in;
                                sda_oe_out <= 1'b1;
                            end else begin
                                state <= ST_IDLE;
                            end
                        end
                    end
                    ST_CACK: begin
                        state <= ST_WDAT;
                        bit_cnt <= 4'h0;
                        sda_oe_out <= 1'b0;
                    end
                    ST_WDAT: begin
                        if (bit_cnt == 4'h8) begin
                            state <= ST_WACK;
                            sda_oe_out <= 1'b1;
                        end
                    end
                    ST_WACK: begin
                        // Commit once the byte has been acknowledged
                        state <= ST_WDAT;
                        bit_cnt <= 4'h0;
                        sda_oe_out <= 1'b0;
                        if (reg_ptr == `SUCR_IDX_RES_HEAT) begin
                            res_heat <= (shift_in & `SUCR_WMASK_RES_HEAT) |
                                (`SUCR_RST_RES_HEAT &
                                 ~`SUCR_WMASK_RES_HEAT);
                        end else if (reg_ptr == `SUCR_IDX_AUX) begin
                            aux_ctrl <= shift_in & `SUCR_WMASK_AUX;
                        end else if (ptr_valid) begin
                            heat_lvl <= shift_in &
                                `SUCR_WMASK_HEAT_LVL;
                        end
                    end
                    ST_RDAT: begin
                        if (bit_cnt == 4'h8) begin
                            state <= ST_RACK;
                            sda_oe_out <= 1'b0;
                        end else begin
                            shift_out <= {shift_out[6:0], 1'b1};
                            sda_oe_out <= ~shift_out[7];
                        end
                    end
                    ST_RACK: begin
                        // Host ack repeats the register, nack ends
                        bit_cnt <= 4'h0;
                        if (host_nack) begin
                            state <= ST_IDLE;
                            sda_oe_out <= 1'b0;
                        end else begin
                            state <= ST_RDAT;
                            shift_out <= {read_byte[6:0], 1'b1};
                            sda_oe_out <= ~read_byte[7];
                        end
                    end
                    ST_IDLE: begin
                        sda_oe_out <= 1'b0;
                    end
                    default: begin
                        state <= ST_IDLE;
                        sda_oe_out <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Open-drain data line only ever pulls low
    assign sda_out = 1'b0;
    // Pin level follows the register bit once the strap is taken
    assign address_select_drive_pin_out =
        aux_ctrl[`SUCR_BIT_DRIVE_PIN];
    // Control outputs from register flip-flops, heater level gated by the switch
    assign resolution_select_out = {res_heat[`SUCR_BIT_RES_MSB],
                                    res_heat[`SUCR_BIT_RES_LSB]};
    assign heater_switch_out = res_heat[`SUCR_BIT_HEATER_SW];
    assign heater_drive_level_out = heat_lvl[`SUCR_HEAT_LVL_MSB:0] &
        {4{res_heat[`SUCR_BIT_HEATER_SW]}};
    assign aux_no_hold_out = aux_ctrl[`SUCR_BIT_NO_HOLD];
    assign thermistor_linearize_en_out =
        aux_ctrl[`SUCR_BIT_THERM_LIN];
    assign aux_conversion_speed_out = aux_ctrl[`SUCR_BIT_CONV_SPEED];
    assign aux_input_buffer_en_out = aux_ctrl[`SUCR_BIT_IN_BUF];
    assign converter_reference_select_out =
        aux_ctrl[`SUCR_BIT_REF_SEL];

endmodule

// >>> dv/sucr_user_config_checker.sv
/* Port checker for the user configuration register bank.
   Assumes it is bound onto sucr_user_config, one clock domain. */
`timescale 1ns/1ps
module sucr_user_config_checker (
    input wire clk_in,
    input wire rst_n_in,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe_out,
    input wire address_select_drive_pin_in,
    input wire address_select_drive_pin_out,
    input wire address_select_drive_pin_oe_out,
    input wire supply_low_in,
    input wire [1:0] resolution_select_out,
    input wire heater_switch_out,
    input wire [3:0] heater_drive_level_out,
    input wire aux_no_hold_out,
    input wire thermistor_linearize_en_out,
    input wire aux_conversion_speed_out,
    input wire aux_input_buffer_en_out,
    input wire converter_reference_select_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // All control outputs that only a committed write may move
    wire [11:0] cfg = {resolution_select_out, heater_switch_out,
        heater_drive_level_out, aux_no_hold_out, thermistor_linearize_en_out,
        aux_conversion_speed_out, aux_input_buffer_en_out,
        converter_reference_select_out};
    heat_gate_a: assert property (
        !heater_switch_out |-> heater_drive_level_out == 4'h0)
        else $error("heater drive active while switch off");
    sda_pull_a: assert property (
        sda_out == 1'b0) else $error("data pin driven high");
    strap_wait_a: assert property (
        $rose(rst_n_in) |-> !address_select_drive_pin_oe_out [*8])
        else $error("pin driven inside strap window");
    pin_hold_a: assert property (
        address_select_drive_pin_oe_out |=> address_select_drive_pin_oe_out)
        else $error("pin drive dropped");
    strap_level_a: assert property (
        $rose(address_select_drive_pin_oe_out) |->
        address_select_drive_pin_out == $past(address_select_drive_pin_in))
        else $error("pin level differs from strap");
    cfg_commit_a: assert property (
        $changed(cfg) |-> !$past(scl_in) && !$past(scl_in, 2))
        else $error("control output moved outside a clock low phase");
    oe_change_a: assert property (
        $changed(sda_oe_out) |-> !$past(scl_in))
        else $error("data drive changed while clock high");
    early_ack_a: assert property (
        !address_select_drive_pin_oe_out |-> !sda_oe_out)
        else $error("bus answered before strap capture");
endmodule

bind sucr_user_config sucr_user_config_checker chk (.clk_in, .rst_n_in,
    .scl_in, .sda_in, .sda_out, .sda_oe_out, .address_select_drive_pin_in,
    .address_select_drive_pin_out, .address_select_drive_pin_oe_out,
    .supply_low_in, .resolution_select_out, .heater_switch_out,
    .heater_drive_level_out, .aux_no_hold_out, .thermistor_linearize_en_out,
    .aux_conversion_speed_out, .aux_input_buffer_en_out,
    .converter_reference_select_out);

// >>> dv/sucr_i2c_host.sv
/* Two-wire bus host model: start, stop, bytes, register access.
   Assumes an open-drain data wire with pull-up, resolved outside. */
`timescale 1ns/1ps
module sucr_i2c_host (
    input wire logic clk_in,
    input wire logic sda_line_in,
    output logic scl_out,
    output logic sda_oe_out
);
    // Bus idles released
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // One bit, 80 ns: data set mid-low, sampled mid-high
    task automatic bit_xfer(input logic b, output logic r);
        tick(2);
        sda_oe_out <= ~b;
        tick(2);
        scl_out <= 1'b1;
        tick(2);
        #1 r = sda_line_in;
        tick(2);
        scl_out <= 1'b0;
    endtask
    // Start or repeated start; long first gap lets an ack end
    task automatic start;
        tick(4);
        sda_oe_out <= 1'b0;
        tick(2);
        scl_out <= 1'b1;
        tick(2);
        sda_oe_out <= 1'b1;
        tick(2);
        scl_out <= 1'b0;
    endtask
    task automatic stop;
        tick(2);
        sda_oe_out <= 1'b1;
        tick(2);
        scl_out <= 1'b1;
        tick(2);
        sda_oe_out <= 1'b0;
        tick(4);
    endtask
    // Byte out, MSB first, then the device answer
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_xfer(d[i], r);
        bit_xfer(1'b1, r);
        ack = ~r;
    endtask
    task automatic write_reg(input logic [6:0] a, input logic [7:0] idx,
        input logic [7:0] d, output logic ok);
        logic k1, k2, k3;
        start;
        send_byte({a, 1'b0}, k1);
        send_byte(idx, k2);
        k3 = 1'b0;
        if (k2) send_byte(d, k3);
        stop;
        ok = k1 & k2 & k3;
    endtask
    // Pointer write, repeated start, one byte back, host nack
    task automatic read_reg(input logic [6:0] a, input logic [7:0] idx,
        output logic [7:0] d);
        logic k, r;
        start;
        send_byte({a, 1'b0}, k);
        send_byte(idx, k);
        start;
        send_byte({a, 1'b1}, k);
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, r);
            d[i] = r;
        end
        bit_xfer(1'b1, r);
        stop;
    endtask
endmodule

// >>> dv/sucr_user_config_tb_top.sv
/* Self-checking bench for the user configuration register bank.
   Assumes the host model and bound checker are compiled before it. */
`timescale 1ns/1ps
`include "sucr_defines.vh"
module sucr_user_config_tb_top;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic supply_low_in = 1'b0;
    logic strap = 1'b1; // Level tied on the dual-function pin
    logic ok;
    logic [7:0] v;
    int mismatches = 0;
    int n_checks = 0;
    wire scl_in, host_oe, sda_in, sda_out, sda_oe_out;
    wire address_select_drive_pin_in, address_select_drive_pin_out;
    wire address_select_drive_pin_oe_out, heater_switch_out;
    wire [1:0] resolution_select_out;
    wire [3:0] heater_drive_level_out;
    wire aux_no_hold_out, thermistor_linearize_en_out;
    wire aux_conversion_speed_out, aux_input_buffer_en_out;
    wire converter_reference_select_out;
    wire [6:0] addr = {`SUCR_BUS_ADDR_HI, strap};
    // Second register as seen at the control outputs
    wire [7:0] aux_view = {1'b0, aux_no_hold_out, thermistor_linearize_en_out,
        aux_conversion_speed_out, 1'b0, aux_input_buffer_en_out,
        converter_reference_select_out, address_select_drive_pin_out};
    always #5 clk_in = ~clk_in;
    // Pull-up on the data wire; either party pulls low
    assign sda_in = ~(host_oe | sda_oe_out);
    // Strap level shows until the device drives the pin
    assign address_select_drive_pin_in = address_select_drive_pin_oe_out ?
        address_select_drive_pin_out : strap;
    sucr_i2c_host host (.clk_in, .sda_line_in(sda_in), .scl_out(scl_in),
        .sda_oe_out(host_oe));
    sucr_user_config uut (.clk_in, .rst_n_in, .scl_in, .sda_in, .sda_out,
        .sda_oe_out, .address_select_drive_pin_in,
        .address_select_drive_pin_out, .address_select_drive_pin_oe_out,
        .supply_low_in, .resolution_select_out, .heater_switch_out,
        .heater_drive_level_out, .aux_no_hold_out,
        .thermistor_linearize_en_out, .aux_conversion_speed_out,
        .aux_input_buffer_en_out, .converter_reference_select_out);
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        host.write_reg(addr, idx, d, ok);
        check("write ack", ok, 8'h01);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        host.read_reg(addr, idx, v);
        check("read data", v, exp);
    endtask
    task automatic do_reset(input logic s);
        rst_n_in <= 1'b0;
        strap <= s;
        repeat (20) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (30) @(posedge clk_in);
    endtask
    // Reset contents and outputs
    task automatic t_defaults;
        rd(`SUCR_IDX_RES_HEAT, 8'h3A);
        rd(`SUCR_IDX_AUX, {7'h04, strap});
        rd(`SUCR_IDX_HEAT_LVL, 8'h00);
        check("aux outputs", aux_view, {7'h00, strap});
        check("resolution", resolution_select_out, 8'h00);
    endtask
    // Every resolution code, heater switch both ways, read-modify-write
    task automatic t_resolution;
        logic [1:0] c;
        logic [7:0] f; // Resolution and heater bits to write
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            f = {c[1], 4'h0, c[0], 1'b0, c[0]};
            host.read_reg(addr, `SUCR_IDX_RES_HEAT, v);
            wr(`SUCR_IDX_RES_HEAT, (v & 8'h7A) | f);
            check("resolution", resolution_select_out, c);
            check("heater switch", heater_switch_out, c[0]);
            rd(`SUCR_IDX_RES_HEAT, {c[1], 4'h7, c[0], 1'b1, c[0]});
        end
        wr(`SUCR_IDX_RES_HEAT, 8'h40);
        rd(`SUCR_IDX_RES_HEAT, 8'h3A);
        supply_low_in <= 1'b1;
        rd(`SUCR_IDX_RES_HEAT, 8'h7A);
        supply_low_in <= 1'b0;
    endtask
    // Auxiliary control bits, each set and cleared
    task automatic t_aux;
        logic [7:0] w [4] = '{8'hFF, 8'h00, 8'h52, 8'h25};
        foreach (w[i]) begin
            wr(`SUCR_IDX_AUX, w[i]);
            check("aux outputs", aux_view, w[i] & 8'h77);
            check("aux pins", aux_view[2:0], w[i][2:0]);
            rd(`SUCR_IDX_AUX, (w[i] & 8'h77) | 8'h08);
        end
        // Host leaves no-hold and correction cleared before measuring
        wr(`SUCR_IDX_AUX, 8'h00);
        check("hold bits", aux_view & 8'h60, 8'h00);
    endtask
    // Heater level codes, gated by the switch
    task automatic t_heater;
        logic [3:0] lv [3] = '{4'h0, 4'h5, 4'hF};
        foreach (lv[i]) begin
            wr(`SUCR_IDX_HEAT_LVL, {4'hF, lv[i]});
            rd(`SUCR_IDX_HEAT_LVL, {4'h0, lv[i]});
            wr(`SUCR_IDX_RES_HEAT, 8'h04);
            check("heater drive", heater_drive_level_out, lv[i]);
            wr(`SUCR_IDX_RES_HEAT, 8'h00);
            check("heater drive", heater_drive_level_out, 8'h00);
        end
    endtask
    // Unlisted index refused, contents kept
    task automatic t_unlisted;
        host.write_reg(addr, 8'h03, 8'hFF, ok);
        check("unlisted ack", ok, 8'h00);
        rd(`SUCR_IDX_HEAT_LVL, 8'h0F);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        do_reset(1'b1);
        t_defaults;
        t_resolution;
        t_aux;
        t_heater;
        t_unlisted;
        do_reset(1'b0);
        t_defaults;
        end_of_test;
    end
    // Hang guard
    initial begin
        repeat (100000) @(posedge clk_in);
        mismatches++;
        end_of_test;
    end
endmodule
